// file: sdb_pkg.sv
package sdb_pkg;

   localparam int unsigned CHAR_W      = 8;
   localparam int unsigned QUEUE_DEPTH = 16;
   localparam int unsigned PTR_W       = 4;
   localparam int unsigned COUNT_W     = 5;
   localparam logic [COUNT_W-1:0] QUEUE_FULL_COUNT = 5'h10;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CTL_TWO    = 16'h7054;
   localparam logic [15:0] IDX_RX_STATUS  = 16'h7055;
   localparam logic [15:0] IDX_RX_PEEK    = 16'h7056;
   localparam logic [15:0] IDX_RX_READ    = 16'h7057;
   localparam logic [15:0] IDX_TX_WRITE   = 16'h7059;
   localparam logic [15:0] IDX_TX_QCTL    = 16'h705a;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h7060;
   localparam logic [15:0] IDX_IRQ_MASK   = 16'h7061;

   // Field positions
   localparam int unsigned RXST_READY_BIT     = 6;
   localparam int unsigned CTL2_TX_FREE_BIT   = 7;
   localparam int unsigned CTL2_RX_IRQ_EN_BIT = 1;
   localparam int unsigned CTL2_TX_IRQ_EN_BIT = 0;
   localparam int unsigned RXBUF_FRAME_BIT    = 15;
   localparam int unsigned RXBUF_PARITY_BIT   = 14;
   localparam int unsigned QCTL_CH_RST_BIT    = 15;
   localparam int unsigned QCTL_EN_BIT        = 14;
   localparam int unsigned QCTL_QRST_BIT      = 13;
   localparam int unsigned QCTL_COUNT_LSB     = 8;
   localparam int unsigned QCTL_FLAG_BIT      = 7;
   localparam int unsigned QCTL_CLR_BIT       = 6;
   localparam int unsigned QCTL_IEN_BIT       = 5;
   localparam int unsigned QCTL_LEVEL_LSB     = 0;
   localparam int unsigned IRQ_TX_BIT         = 0;
   localparam int unsigned IRQ_RX_BIT         = 1;
   localparam int unsigned IRQ_QUEUE_BIT      = 2;
   localparam int unsigned IRQ_W              = 3;

   // Reset values
   localparam logic       QCTL_CH_RST_RST  = 1'b1;
   localparam logic       QCTL_EN_RST      = 1'b0;
   localparam logic       QCTL_QRST_RST    = 1'b1;
   localparam logic       QCTL_IEN_RST     = 1'b0;
   localparam logic [4:0] QCTL_LEVEL_RST   = 5'h00;
   localparam logic       CTL2_IRQ_EN_RST  = 1'b0;
   localparam logic [2:0] IRQ_MASK_RST     = 3'h0;

   localparam logic [1:0] AXI_RESP_OKAY   = 2'h0;
   localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic             frameErr;
      logic             parityErr;
      logic [CHAR_W-1:0] data;
   } sdb_rx_char_t;

   typedef struct packed {
      logic       chanResetN;
      logic       queueEnable;
      logic       queueResetN;
      logic       irqEnable;
      logic [4:0] irqLevel;
   } sdb_qctl_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b00,
      WR_APPLY   = 2'b01,
      WR_RESP    = 2'b10
   } sdb_wr_state_t;

endpackage : sdb_pkg

// file: sdb_tx_queue.sv
`timescale 1ns/10ps
module sdb_tx_queue (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_b,
   input  wire logic                        clkEn,
   input  wire logic                        flush,
   input  wire logic                        singleMode,
   input  wire logic                        pushValid,
   input  wire logic [sdb_pkg::CHAR_W-1:0]  pushData,
   output logic                             pushReady,
   input  wire logic                        popReady,
   output logic                             popValid,
   output logic [sdb_pkg::CHAR_W-1:0]       popData,
   output logic [sdb_pkg::COUNT_W-1:0]      count
);

   logic [sdb_pkg::CHAR_W-1:0]  memQ [sdb_pkg::QUEUE_DEPTH];
   logic [sdb_pkg::PTR_W-1:0]   wrPtrQ;
   logic [sdb_pkg::PTR_W-1:0]   rdPtrQ;
   logic [sdb_pkg::COUNT_W-1:0] countQ;
   logic                        full;
   logic                        doPush;
   logic                        doPop;

   // With the queue disabled it behaves as a single holding buffer
   assign full      = singleMode ? (countQ != 5'h00)
                                 : (countQ == sdb_pkg::QUEUE_FULL_COUNT);
   assign pushReady = !flush && !full;
   assign popValid  = !flush && (countQ != 5'h00);
   assign popData   = memQ[rdPtrQ];
   assign count     = countQ;
   assign doPush    = clkEn && pushValid && pushReady;
   assign doPop     = clkEn && popValid && popReady;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtrQ <= 4'h0;
         rdPtrQ <= 4'h0;
         countQ <= 5'h00;
      end else if (clkEn) begin
         if (flush) begin
            wrPtrQ <= 4'h0;
            rdPtrQ <= 4'h0;
            countQ <= 5'h00;
         end else begin
            if (doPush)
               wrPtrQ <= wrPtrQ + 4'h1;
            if (doPop)
               rdPtrQ <= rdPtrQ + 4'h1;
            countQ <= countQ + 5'(doPush) - 5'(doPop);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < sdb_pkg::QUEUE_DEPTH; i++)
            memQ[i] <= 8'h00;
      end else if (doPush) begin
         memQ[wrPtrQ] <= pushData;
      end
   end

   AST_QUEUE_FLUSH: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (clkEn && flush) |=> (countQ == 5'h00) && !popValid)
      else $error("Queue not emptied by flush");

   AST_QUEUE_BOUND: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      countQ <= sdb_pkg::QUEUE_FULL_COUNT)
      else $error("Queue count beyond depth");

endmodule : sdb_tx_queue

// file: sdb_data_buffers.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - A character moved into the receive buffer sets the ready flag.
// - Peek and read addresses return the same single buffered character.
// - Reading the read address clears ready; reading peek does not.
// - Peek reads may repeat forever without touching the ready flag.
// - System reset zeroes the receive buffer, so peek returns zero too.
// - With the receive irq enable set, each received character sets the receive irq status bit.
// - With the queue enabled, bit 15 of the read register is framing error.
// - With the queue enabled, bit 14 of the read register is parity error.
// - The error flags travel with the character they describe.
// - A transfer to the transmit shifter sets the buffer-free flag.
// - With the transmit irq enable set, each such transfer sets the transmit irq status bit.
// - Channel reset low resets both channels but keeps queue settings.
// - Queue reset low empties the transmit queue and holds it empty.
// - With the queue enabled, the queue flag sets while fill count is at or below the level.
// - Writing one to the clear bit clears the queue flag unless the queue is enabled with fill at or below the level; it reads zero.
module sdb_data_buffers (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_b,
   input  wire logic                        clkEn,
   input  wire logic [31:0]                 awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [31:0]                 araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   input  wire logic                        rxCharValid,
   input  wire sdb_pkg::sdb_rx_char_t       rxCharIn,
   output logic                             txCharValid,
   output logic [sdb_pkg::CHAR_W-1:0]       txChar,
   input  wire logic                        txShiftReady,
   output logic                             irq
);

   function automatic logic hitIdx(input logic [31:0] addr,
                                   input logic [15:0] idx);
      hitIdx = (addr == {14'h0000, idx, 2'b00});
   endfunction : hitIdx

   function automatic logic isMapped(input logic [31:0] addr);
      isMapped = hitIdx(addr, sdb_pkg::IDX_CTL_TWO)
              || hitIdx(addr, sdb_pkg::IDX_RX_STATUS)
              || hitIdx(addr, sdb_pkg::IDX_RX_PEEK)
              || hitIdx(addr, sdb_pkg::IDX_RX_READ)
              || hitIdx(addr, sdb_pkg::IDX_TX_WRITE)
              || hitIdx(addr, sdb_pkg::IDX_TX_QCTL)
              || hitIdx(addr, sdb_pkg::IDX_IRQ_STATUS)
              || hitIdx(addr, sdb_pkg::IDX_IRQ_MASK);
   endfunction : isMapped

   sdb_pkg::sdb_wr_state_t      wrStateQ;
   logic [31:0]                 awAddrQ;
   logic [15:0]                 wDataQ;
   logic [1:0]                  wStrbQ;
   logic                        awHeldQ;
   logic                        wHeldQ;
   logic [1:0]                  brespQ;
   logic                        rvalidQ;
   logic [31:0]                 rdataQ;
   logic [1:0]                  rrespQ;
   logic [31:0]                 rdMux;
   logic                        awFire;
   logic                        wFire;
   logic                        arFire;
   logic                        wrApply;
   logic                        wrLo;
   logic                        wrHi;
   logic                        rdReadAddr;
   logic                        rdPeekAddr;

   sdb_pkg::sdb_rx_char_t       rxBufQ;
   logic                        rxReadyQ;
   sdb_pkg::sdb_qctl_t          qctlQ;
   logic                        qIrqFlagQ;
   logic                        rxIrqEnQ;
   logic                        txIrqEnQ;
   logic [sdb_pkg::IRQ_W-1:0]   irqStatusQ;
   logic [sdb_pkg::IRQ_W-1:0]   irqMaskQ;
   logic [sdb_pkg::IRQ_W-1:0]   irqEvents;
   logic [sdb_pkg::CHAR_W-1:0]  txLastQ;
   logic                        chanRun;
   logic                        txPush;
   logic                        txBufferFree;
   logic                        queueValid;
   logic                        txTake;
   logic [sdb_pkg::COUNT_W-1:0] queueCount;

   // Bus handshakes are gated by the clock enable so no beat is lost
   assign awFire  = awvalid && awready;
   assign wFire   = wvalid && wready;
   assign arFire  = arvalid && arready;
   assign awready = clkEn && (wrStateQ == sdb_pkg::WR_COLLECT) && !awHeldQ;
   assign wready  = clkEn && (wrStateQ == sdb_pkg::WR_COLLECT) && !wHeldQ;
   assign bvalid  = clkEn && (wrStateQ == sdb_pkg::WR_RESP);
   assign bresp   = brespQ;
   assign arready = clkEn && !rvalidQ;
   assign rvalid  = clkEn && rvalidQ;
   assign rdata   = rdataQ;
   assign rresp   = rrespQ;

   assign wrApply = clkEn && (wrStateQ == sdb_pkg::WR_APPLY);
   assign wrLo    = wrApply && wStrbQ[0];
   assign wrHi    = wrApply && wStrbQ[1];
   assign rdReadAddr = arFire && hitIdx(araddr, sdb_pkg::IDX_RX_READ);
   assign rdPeekAddr = arFire && hitIdx(araddr, sdb_pkg::IDX_RX_PEEK);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrStateQ <= sdb_pkg::WR_COLLECT;
         awAddrQ  <= 32'h0000_0000;
         wDataQ   <= 16'h0000;
         wStrbQ   <= 2'h0;
         awHeldQ  <= 1'b0;
         wHeldQ   <= 1'b0;
         brespQ   <= sdb_pkg::AXI_RESP_OKAY;
      end else if (clkEn) begin
         case (wrStateQ)
            sdb_pkg::WR_COLLECT: begin
               if (awFire) begin
                  awAddrQ <= awaddr;
                  awHeldQ <= 1'b1;
               end
               if (wFire) begin
                  wDataQ <= wdata[15:0];
                  wStrbQ <= wstrb[1:0];
                  wHeldQ <= 1'b1;
               end
               if ((awHeldQ || awFire) && (wHeldQ || wFire))
                  wrStateQ <= sdb_pkg::WR_APPLY;
            end
            sdb_pkg::WR_APPLY: begin
               brespQ   <= isMapped(awAddrQ) ? sdb_pkg::AXI_RESP_OKAY
                                             : sdb_pkg::AXI_RESP_SLVERR;
               awHeldQ  <= 1'b0;
               wHeldQ   <= 1'b0;
               wrStateQ <= sdb_pkg::WR_RESP;
            end
            sdb_pkg::WR_RESP: begin
               if (bready)
                  wrStateQ <= sdb_pkg::WR_COLLECT;
            end
            default: wrStateQ <= sdb_pkg::WR_COLLECT;
         endcase
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      if (hitIdx(araddr, sdb_pkg::IDX_RX_PEEK)) begin
         rdMux[7:0] = rxBufQ.data;
      end else if (hitIdx(araddr, sdb_pkg::IDX_RX_READ)) begin
         rdMux[7:0] = rxBufQ.data;
         if (qctlQ.queueEnable) begin
            rdMux[sdb_pkg::RXBUF_FRAME_BIT]  = rxBufQ.frameErr;
            rdMux[sdb_pkg::RXBUF_PARITY_BIT] = rxBufQ.parityErr;
         end
      end else if (hitIdx(araddr, sdb_pkg::IDX_RX_STATUS)) begin
         rdMux[sdb_pkg::RXST_READY_BIT] = rxReadyQ;
      end else if (hitIdx(araddr, sdb_pkg::IDX_CTL_TWO)) begin
         rdMux[sdb_pkg::CTL2_TX_FREE_BIT]   = txBufferFree;
         rdMux[sdb_pkg::CTL2_RX_IRQ_EN_BIT] = rxIrqEnQ;
         rdMux[sdb_pkg::CTL2_TX_IRQ_EN_BIT] = txIrqEnQ;
      end else if (hitIdx(araddr, sdb_pkg::IDX_TX_WRITE)) begin
         rdMux[7:0] = txLastQ;
      end else if (hitIdx(araddr, sdb_pkg::IDX_TX_QCTL)) begin
         rdMux[sdb_pkg::QCTL_CH_RST_BIT] = qctlQ.chanResetN;
         rdMux[sdb_pkg::QCTL_EN_BIT]     = qctlQ.queueEnable;
         rdMux[sdb_pkg::QCTL_QRST_BIT]   = qctlQ.queueResetN;
         rdMux[sdb_pkg::QCTL_COUNT_LSB +: sdb_pkg::COUNT_W] = queueCount;
         rdMux[sdb_pkg::QCTL_FLAG_BIT]   = qIrqFlagQ;
         rdMux[sdb_pkg::QCTL_IEN_BIT]    = qctlQ.irqEnable;
         rdMux[sdb_pkg::QCTL_LEVEL_LSB +: 5] = qctlQ.irqLevel;
      end else if (hitIdx(araddr, sdb_pkg::IDX_IRQ_STATUS)) begin
         rdMux[sdb_pkg::IRQ_W-1:0] = irqStatusQ;
      end else if (hitIdx(araddr, sdb_pkg::IDX_IRQ_MASK)) begin
         rdMux[sdb_pkg::IRQ_W-1:0] = irqMaskQ;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalidQ <= 1'b0;
         rdataQ  <= 32'h0000_0000;
         rrespQ  <= sdb_pkg::AXI_RESP_OKAY;
      end else if (clkEn) begin
         if (arFire) begin
            rvalidQ <= 1'b1;
            rdataQ  <= rdMux;
            rrespQ  <= isMapped(araddr) ? sdb_pkg::AXI_RESP_OKAY
                                        : sdb_pkg::AXI_RESP_SLVERR;
         end else if (rready) begin
            rvalidQ <= 1'b0;
         end
      end
   end

   // Channel reset stops traffic but leaves every setting untouched
   assign chanRun = qctlQ.chanResetN;

   // Data and its error flags are captured as one unit
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxBufQ <= '0;
      end else if (clkEn && rxCharValid && chanRun) begin
         rxBufQ <= rxCharIn;
      end
   end

   // A new character wins over a read that clears in the same cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxReadyQ <= 1'b0;
      end else if (clkEn) begin
         if (!chanRun)
            rxReadyQ <= 1'b0;
         else if (rxCharValid)
            rxReadyQ <= 1'b1;
         else if (rdReadAddr)
            rxReadyQ <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         qctlQ.chanResetN  <= sdb_pkg::QCTL_CH_RST_RST;
         qctlQ.queueEnable <= sdb_pkg::QCTL_EN_RST;
         qctlQ.queueResetN <= sdb_pkg::QCTL_QRST_RST;
         qctlQ.irqEnable   <= sdb_pkg::QCTL_IEN_RST;
         qctlQ.irqLevel    <= sdb_pkg::QCTL_LEVEL_RST;
      end else if (hitIdx(awAddrQ, sdb_pkg::IDX_TX_QCTL)) begin
         if (wrHi) begin
            qctlQ.chanResetN  <= wDataQ[sdb_pkg::QCTL_CH_RST_BIT];
            qctlQ.queueEnable <= wDataQ[sdb_pkg::QCTL_EN_BIT];
            qctlQ.queueResetN <= wDataQ[sdb_pkg::QCTL_QRST_BIT];
         end
         if (wrLo) begin
            qctlQ.irqEnable <= wDataQ[sdb_pkg::QCTL_IEN_BIT];
            qctlQ.irqLevel  <= wDataQ[sdb_pkg::QCTL_LEVEL_LSB +: 5];
         end
      end
   end

   // Level-driven flag: a clear only sticks while the fill is above level or the queue is disabled
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         qIrqFlagQ <= 1'b0;
      end else if (clkEn) begin
         if (qctlQ.queueEnable && queueCount <= qctlQ.irqLevel)
            qIrqFlagQ <= 1'b1;
         else if (wrLo && hitIdx(awAddrQ, sdb_pkg::IDX_TX_QCTL)
                  && wDataQ[sdb_pkg::QCTL_CLR_BIT])
            qIrqFlagQ <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxIrqEnQ <= sdb_pkg::CTL2_IRQ_EN_RST;
         txIrqEnQ <= sdb_pkg::CTL2_IRQ_EN_RST;
         irqMaskQ <= sdb_pkg::IRQ_MASK_RST;
         txLastQ  <= 8'h00;
      end else begin
         if (wrLo && hitIdx(awAddrQ, sdb_pkg::IDX_CTL_TWO)) begin
            rxIrqEnQ <= wDataQ[sdb_pkg::CTL2_RX_IRQ_EN_BIT];
            txIrqEnQ <= wDataQ[sdb_pkg::CTL2_TX_IRQ_EN_BIT];
         end
         if (wrLo && hitIdx(awAddrQ, sdb_pkg::IDX_IRQ_MASK))
            irqMaskQ <= wDataQ[sdb_pkg::IRQ_W-1:0];
         if (wrLo && hitIdx(awAddrQ, sdb_pkg::IDX_TX_WRITE))
            txLastQ <= wDataQ[7:0];
      end
   end

   assign irqEvents[sdb_pkg::IRQ_TX_BIT]    = txTake && txIrqEnQ;
   assign irqEvents[sdb_pkg::IRQ_RX_BIT]    = clkEn && rxCharValid
                                              && chanRun && rxIrqEnQ;
   assign irqEvents[sdb_pkg::IRQ_QUEUE_BIT] = clkEn && qIrqFlagQ
                                              && qctlQ.irqEnable;

   // Events win over a write-one-to-clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStatusQ <= 3'h0;
      end else if (clkEn) begin
         if (wrLo && hitIdx(awAddrQ, sdb_pkg::IDX_IRQ_STATUS))
            irqStatusQ <= (irqStatusQ & ~wDataQ[sdb_pkg::IRQ_W-1:0])
                          | irqEvents;
         else
            irqStatusQ <= irqStatusQ | irqEvents;
      end
   end

   assign irq = |(irqStatusQ & irqMaskQ);

   // A write to a full buffer is dropped; software polls the free flag
   assign txPush = wrLo && hitIdx(awAddrQ, sdb_pkg::IDX_TX_WRITE) && chanRun;
   assign txCharValid = queueValid && chanRun;
   assign txTake = clkEn && txCharValid && txShiftReady;

   sdb_tx_queue u_tx_queue (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .clkEn      (clkEn),
      .flush      (!chanRun || !qctlQ.queueResetN),
      .singleMode (!qctlQ.queueEnable),
      .pushValid  (txPush),
      .pushData   (wDataQ[7:0]),
      .pushReady  (txBufferFree),
      .popReady   (txShiftReady && chanRun),
      .popValid   (queueValid),
      .popData    (txChar),
      .count      (queueCount)
   );

   AST_RX_READY_SET: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (clkEn && rxCharValid && chanRun) |=> rxReadyQ)
      else $error("Ready flag not set by received character");

   AST_ALIAS_DATA: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (rdPeekAddr || rdReadAddr) |=> rdataQ[7:0] == $past(rxBufQ.data))
      else $error("Alias read returned other data");

   AST_READ_CLEARS: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (rdReadAddr && !rxCharValid) |=> !rxReadyQ)
      else $error("Read address did not clear ready");

   AST_PEEK_KEEPS: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (rdPeekAddr && !rxCharValid && chanRun) |=> $stable(rxReadyQ))
      else $error("Peek read changed ready flag");

   AST_RX_IRQ: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (clkEn && rxCharValid && chanRun && rxIrqEnQ)
      |=> irqStatusQ[sdb_pkg::IRQ_RX_BIT])
      else $error("Receive interrupt not raised");

   AST_ERR_GATED: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (rdReadAddr && !qctlQ.queueEnable) |=> rdataQ[15:8] == 8'h00)
      else $error("Error flags shown with queue disabled");

   AST_TX_FREE: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (txTake && !qctlQ.queueEnable && !txPush) |=> txBufferFree)
      else $error("Buffer not free after transfer");

   AST_TX_IRQ: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (txTake && txIrqEnQ) |=> irqStatusQ[sdb_pkg::IRQ_TX_BIT])
      else $error("Transmit interrupt not raised");

   AST_CHAN_RESET: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (clkEn && !chanRun) |=> !rxReadyQ && queueCount == 5'h00)
      else $error("Channel reset did not clear channels");

   AST_QUEUE_FLAG: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (clkEn && qctlQ.queueEnable && queueCount <= qctlQ.irqLevel)
      |=> qIrqFlagQ)
      else $error("Queue flag not set at level");

endmodule : sdb_data_buffers

// file: sdb_far_node.sv
`timescale 1ns/10ps
module sdb_far_node (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   input  wire logic                  txCharValid,
   input  wire logic [7:0]            txChar,
   output logic                       txShiftReady,
   output logic                       rxCharValid,
   output sdb_pkg::sdb_rx_char_t      rxCharIn,
   output logic [7:0]                 lastTx
);
   logic stall_q;
   initial begin
      rxCharValid = 1'b0;
      rxCharIn = '0;
      lastTx = '0;
   end
   // Shifter is slow: takes a char only every other cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) stall_q <= 1'b0;
      else stall_q <= ~stall_q;
   end
   assign txShiftReady = stall_q;
   always @(posedge ref_clk) if (txCharValid && txShiftReady) lastTx <= txChar;
   // Data is not held after the pulse, so show the inverse
   task automatic send(input sdb_pkg::sdb_rx_char_t c);
      rxCharValid <= 1'b1;
      rxCharIn <= c;
      @(posedge ref_clk);
      rxCharValid <= 1'b0;
      rxCharIn <= ~c;
   endtask : send
endmodule : sdb_far_node

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic                  ref_clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic [31:0]           awaddr = '0, wdata = '0, araddr = '0, rdata, d;
   logic [1:0]            bresp, rresp, rsp;
   logic                  awvalid = 0, wvalid = 0, bready = 0;
   logic                  arvalid = 0, rready = 0, awready, wready, bvalid;
   logic                  arready, rvalid, rxCharValid, txCharValid;
   logic                  txShiftReady, irq, clkEn = 1'b1;
   logic [7:0]            txChar, lastTx;
   sdb_pkg::sdb_rx_char_t rxCharIn;
   int                    err_count = 0, cmp_count = 0, cyc = 0;
   always #10 ref_clk = ~ref_clk;
   sdb_data_buffers u_sdb_data_buffers (.ref_clk(ref_clk), .rst_b(rst_b),
      .clkEn(clkEn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .rxCharValid(rxCharValid),
      .rxCharIn(rxCharIn), .txCharValid(txCharValid), .txChar(txChar),
      .txShiftReady(txShiftReady), .irq(irq));
   sdb_far_node u_sdb_far_node (.ref_clk(ref_clk), .rst_b(rst_b),
      .txCharValid(txCharValid), .txChar(txChar),
      .txShiftReady(txShiftReady), .rxCharValid(rxCharValid),
      .rxCharIn(rxCharIn), .lastTx(lastTx));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // Ready and valid sampled mid-cycle, where they are settled
   task automatic wr(input logic [15:0] idx, input logic [31:0] v);
      logic a, w, b;
      @(posedge ref_clk);
      awaddr <= {14'h0, idx, 2'b00};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge ref_clk);
         a = awready;
         w = wready;
         b = bvalid;
         @(posedge ref_clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] idx, output logic [31:0] q);
      logic a, v;
      @(posedge ref_clk);
      araddr <= {14'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge ref_clk);
         a = arready;
         v = rvalid;
         q = rdata;
         rsp = rresp;
         @(posedge ref_clk);
         if (a) arvalid <= 1'b0;
      end while (!v);
      rready <= 1'b0;
   endtask : rd
   task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] e);
      rd(idx, d);
      chk(nm, d, e);
   endtask : rdc
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      rdc("peek", sdb_pkg::IDX_RX_PEEK, 32'h0);
      rdc("qctl", sdb_pkg::IDX_TX_QCTL, 32'ha000);
      rdc("unmapped", 16'h7058, 32'h0);
      chk("resp", rsp, sdb_pkg::AXI_RESP_SLVERR);
      $display("test reset done");
      wr(sdb_pkg::IDX_CTL_TWO, 32'h3);
      wr(sdb_pkg::IDX_IRQ_MASK, 32'h7);
      wr(sdb_pkg::IDX_TX_WRITE, 32'h1a5);
      while (lastTx !== 8'ha5) @(posedge ref_clk);
      rdc("txwr", sdb_pkg::IDX_TX_WRITE, 32'ha5);
      rdc("ctl2", sdb_pkg::IDX_CTL_TWO, 32'h83);
      rdc("irqst", sdb_pkg::IDX_IRQ_STATUS, 32'h1);
      wr(sdb_pkg::IDX_IRQ_STATUS, 32'h1);
      @(negedge ref_clk) chk("irq", irq, 1'b0);
      $display("test tx done");
      wr(sdb_pkg::IDX_IRQ_MASK, 32'h0);
      u_sdb_far_node.send({1'b1, 1'b1, 8'h5a});
      @(negedge ref_clk) chk("irq", irq, 1'b0);
      rdc("irqst", sdb_pkg::IDX_IRQ_STATUS, 32'h2);
      wr(sdb_pkg::IDX_IRQ_MASK, 32'h2);
      @(negedge ref_clk) chk("irq", irq, 1'b1);
      rdc("rxst", sdb_pkg::IDX_RX_STATUS, 32'h40);
      repeat (2) rdc("peek", sdb_pkg::IDX_RX_PEEK, 32'h5a);
      rdc("rxst", sdb_pkg::IDX_RX_STATUS, 32'h40);
      rdc("rxrd", sdb_pkg::IDX_RX_READ, 32'h5a);
      rdc("rxst", sdb_pkg::IDX_RX_STATUS, 32'h0);
      wr(sdb_pkg::IDX_TX_QCTL, 32'he000);
      rdc("qctl", sdb_pkg::IDX_TX_QCTL, 32'he080);
      u_sdb_far_node.send({1'b1, 1'b0, 8'h3c});
      rdc("rxrd", sdb_pkg::IDX_RX_READ, 32'h803c);
      u_sdb_far_node.send({1'b0, 1'b1, 8'hc3});
      rdc("rxrd", sdb_pkg::IDX_RX_READ, 32'h40c3);
      $display("test rx done");
      wr(sdb_pkg::IDX_TX_QCTL, 32'he020);
      rdc("irqst", sdb_pkg::IDX_IRQ_STATUS, 32'h6);
      repeat (2) wr(sdb_pkg::IDX_TX_QCTL, 32'ha040);
      rdc("qctl", sdb_pkg::IDX_TX_QCTL, 32'ha000);
      u_sdb_far_node.send({1'b0, 1'b0, 8'h11});
      @(posedge ref_clk);
      clkEn <= 1'b0;
      u_sdb_far_node.send({1'b0, 1'b0, 8'h22});
      clkEn <= 1'b1;
      rdc("peek", sdb_pkg::IDX_RX_PEEK, 32'h11);
      wr(sdb_pkg::IDX_TX_QCTL, 32'h2000);
      rdc("rxst", sdb_pkg::IDX_RX_STATUS, 32'h0);
      rdc("qctl", sdb_pkg::IDX_TX_QCTL, 32'h2000);
      wr(sdb_pkg::IDX_TX_WRITE, 32'h66);
      rdc("peek", sdb_pkg::IDX_RX_PEEK, 32'h11);
      chk("txheld", lastTx, 32'ha5);
      wr(sdb_pkg::IDX_TX_QCTL, 32'h8000);
      wr(sdb_pkg::IDX_TX_WRITE, 32'h77);
      rdc("ctl2", sdb_pkg::IDX_CTL_TWO, 32'h3);
      chk("txheld", lastTx, 32'ha5);
      $display("test queue done");
      give_verdict();
   end
endmodule : tb_top
